// [hdl/rrf_top.sv]
/*
 * Receive-ready flag, receive interrupt and idle-line wake gap.
 * Assumes the frame decoder and transmit shifter run on clk_in and
 * drive the rx event and tx_load_in without synchronisers.
 */
`timescale 1ns/1ps
`include "rrf_regs.svh"

module rrf_top (
   input  wire logic                    clk_in,
   input  wire logic                    rst_n_in,
   input  wire logic [`RRF_ADDR_W-1:0]  addr_in,
   input  wire logic [31:0]             wdata_in,
   input  wire logic                    wr_in,
   input  wire logic                    rd_in,
   output logic      [31:0]             rdata_out,
   input  wire rrf_pkg::rrf_rx_event_type rx_event_in,
   input  wire logic                    tx_load_in,
   output logic      [7:0]              tx_data_out,
   output logic                         tx_data_valid_out,
   output logic                         tx_addr_frame_out,
   output logic                         tx_idle_hold_out,
   output logic                         bit_tick_out,
   output logic                         irq_out
);

   // ===========================================================
   // state
   rrf_pkg::rrf_ctrl_type ctrl_q;
   rrf_pkg::rrf_mode_type mode;
   logic [15:0] baud_q;
   logic [15:0] div_q;
   logic        rx_rdy_q;
   logic        rx_rdy_d;
   logic [7:0]  rx_data_q;
   logic        err_seen_q;
   logic        int_en_q;
   logic        gap_en_q;
   logic [9:0]  stat_q;
   logic        wake_q;
   logic        addr_pend_q;
   logic        tx_full_q;
   logic [7:0]  tx_buf_q;
   logic        gap_start;
   logic        gap_busy;
   logic        gap_busy_q;
   logic        mod_held;
   logic        rx_set;
   logic        rx_clr;
   logic        wr_ctrl, wr_flags, wr_td, wr_wake, wr_stat;
   logic        rd_rx, rd_last, rd_vect;
   logic [7:0]  vect;

   // ===========================================================
   // decode
   assign wr_ctrl  = wr_in && (addr_in == `RRF_OFF_CTRL);
   assign wr_flags = wr_in && (addr_in == `RRF_OFF_FLAGS);
   assign wr_td    = wr_in && (addr_in == `RRF_OFF_TX_DATA);
   assign wr_wake  = wr_in && (addr_in == `RRF_OFF_TX_WAKE);
   assign wr_stat  = wr_in && (addr_in == `RRF_OFF_INT_STAT);
   assign rd_rx    = rd_in && (addr_in == `RRF_OFF_RX_DATA);
   assign rd_last  = rd_in && (addr_in == `RRF_OFF_RX_LAST);
   assign rd_vect  = rd_in && (addr_in == `RRF_OFF_VECT);
   // module reset bit set, or soft hold not released, keeps the flag logic cleared
   assign mod_held = ctrl_q.mod_rst || !ctrl_q.soft_rel;
   assign mode = !ctrl_q.lin ? rrf_pkg::RRF_MODE_COMPAT :
                 ctrl_q.mbuf ? rrf_pkg::RRF_MODE_LIN_MB : rrf_pkg::RRF_MODE_LIN_ONE;

   // ===========================================================
   // control and baud registers
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ctrl_q <= `RRF_CTRL_RST;
         baud_q <= `RRF_BAUD_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= wdata_in[4:0];
         end
         if (wr_in && (addr_in == `RRF_OFF_BAUD)) begin
            baud_q <= wdata_in[15:0];
         end
      end
   end

   // ===========================================================
   // bit-rate divider: one-cycle tick per bit period
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         div_q        <= 16'h0000;
         bit_tick_out <= 1'b0;
      end else if (div_q >= baud_q) begin
         div_q        <= 16'h0000;
         bit_tick_out <= 1'b1;
      end else begin
         div_q        <= div_q + 16'h0001;
         bit_tick_out <= 1'b0;
      end
   end

   // ===========================================================
   // set conditions per mode; in both LIN modes errors anywhere in a frame spoil its last byte
   always_comb begin
      rx_set = 1'b0;
      unique case (mode)
         rrf_pkg::RRF_MODE_COMPAT:  rx_set = rx_event_in.valid;
         rrf_pkg::RRF_MODE_LIN_ONE: rx_set = rx_event_in.valid &&
            !(rx_event_in.last && (rx_event_in.err || err_seen_q));
         rrf_pkg::RRF_MODE_LIN_MB:  rx_set = rx_event_in.valid && rx_event_in.last &&
            !rx_event_in.err && !err_seen_q;
         default: rx_set = 1'b0;
      endcase
   end

   // vector reads are deliberately absent from the clear terms
   assign rx_clr = (rd_rx && !ctrl_q.lin) || (rd_last && ctrl_q.lin) ||
                   (wr_flags && wdata_in[`RRF_RX_RDY_BIT]);

   // ===========================================================
   // receive-ready flag: resets dominate, then set beats clear
   always_comb begin
      rx_rdy_d = rx_rdy_q;
      if (mod_held) begin
         rx_rdy_d = 1'b0;
      end else if (rx_set) begin
         rx_rdy_d = 1'b1;
      end else if (rx_clr) begin
         rx_rdy_d = 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rx_rdy_q <= 1'b0;
      end else begin
         rx_rdy_q <= rx_rdy_d;
      end
   end

   // ===========================================================
   // receive data capture and frame error memory
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || mod_held) begin
         rx_data_q  <= 8'h00;
         err_seen_q <= 1'b0;
      end else if (rx_event_in.valid) begin
         rx_data_q  <= rx_event_in.data;
         err_seen_q <= rx_event_in.err && !rx_event_in.last ? 1'b1 :
                       (rx_event_in.last ? 1'b0 : err_seen_q);
      end
   end

   // ===========================================================
   // interrupt enables: set and clear registers, write one to act
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         int_en_q <= 1'b0;
         gap_en_q <= 1'b0;
      end else if (wr_in && (addr_in == `RRF_OFF_INT_SET)) begin
         int_en_q <= int_en_q | wdata_in[`RRF_RX_RDY_BIT];
         gap_en_q <= gap_en_q | wdata_in[`RRF_GAP_DONE_BIT];
      end else if (wr_in && (addr_in == `RRF_OFF_INT_CLR)) begin
         int_en_q <= int_en_q & ~wdata_in[`RRF_RX_RDY_BIT];
         gap_en_q <= gap_en_q & ~wdata_in[`RRF_GAP_DONE_BIT];
      end
   end

   // ===========================================================
   // sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || mod_held) begin
         stat_q <= 10'h000;
      end else begin
         if (rx_set) begin
            stat_q[`RRF_RX_RDY_BIT] <= 1'b1;
         end else if (wr_stat && wdata_in[`RRF_RX_RDY_BIT]) begin
            stat_q[`RRF_RX_RDY_BIT] <= 1'b0;
         end
         if (gap_busy_q && !gap_busy) begin
            stat_q[`RRF_GAP_DONE_BIT] <= 1'b1;
         end else if (wr_stat && wdata_in[`RRF_GAP_DONE_BIT]) begin
            stat_q[`RRF_GAP_DONE_BIT] <= 1'b0;
         end
      end
   end

   // level interrupt while an enabled status bit stands
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= (stat_q[`RRF_RX_RDY_BIT] && int_en_q) ||
                    (stat_q[`RRF_GAP_DONE_BIT] && gap_en_q);
      end
   end

   // ===========================================================
   // wake select: only the system reset, the shifter load, a gap start and a write of zero clear it
   assign gap_start = wr_td && wake_q && ctrl_q.idle_line;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wake_q <= 1'b0;
      end else if (tx_load_in || gap_start) begin
         wake_q <= 1'b0;
      end else if (wr_wake) begin
         wake_q <= wdata_in[`RRF_WAKE_BIT];
      end
   end

   // ===========================================================
   // transmit buffer; the dummy write of a wake gap is never sent
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || mod_held) begin
         tx_full_q         <= 1'b0;
         tx_buf_q          <= 8'h00;
         tx_addr_frame_out <= 1'b0;
         addr_pend_q       <= 1'b0;
      end else if (gap_start) begin
         addr_pend_q <= 1'b1;
      end else if (wr_td) begin
         tx_full_q         <= 1'b1;
         tx_buf_q          <= wdata_in[7:0];
         tx_addr_frame_out <= ctrl_q.idle_line ? addr_pend_q : wake_q;
         addr_pend_q       <= 1'b0;
      end else if (tx_load_in) begin
         tx_full_q <= 1'b0;
      end
   end

   // hold the frame back from the shifter while the gap runs
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tx_data_out       <= 8'h00;
         tx_data_valid_out <= 1'b0;
         gap_busy_q        <= 1'b0;
      end else begin
         tx_data_out       <= tx_buf_q;
         tx_data_valid_out <= tx_full_q && !gap_busy && !tx_load_in;
         gap_busy_q        <= gap_busy;
      end
   end

   rrf_idle_gap u_gap (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .start_in (gap_start),
      .tick_in  (bit_tick_out),
      .busy_out (gap_busy)
   );
   assign tx_idle_hold_out = gap_busy;

   // ===========================================================
   // read port: data in the cycle after the strobe, unmapped reads zero
   assign vect = (stat_q[`RRF_RX_RDY_BIT] && int_en_q) ? `RRF_VECT_RX :
                 (stat_q[`RRF_GAP_DONE_BIT] && gap_en_q) ? `RRF_VECT_GAP : `RRF_VECT_NONE;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rdata_out <= 32'h0000_0000;
      end else if (rd_in) begin
         rdata_out <= 32'h0000_0000;
         unique case (addr_in)
            `RRF_OFF_CTRL:     rdata_out[4:0] <= ctrl_q;
            `RRF_OFF_INT_SET,
            `RRF_OFF_INT_CLR: begin
               rdata_out[`RRF_RX_RDY_BIT]   <= int_en_q;
               rdata_out[`RRF_GAP_DONE_BIT] <= gap_en_q;
            end
            `RRF_OFF_FLAGS:    rdata_out[`RRF_RX_RDY_BIT] <= rx_rdy_q;
            `RRF_OFF_TX_WAKE:  rdata_out[`RRF_WAKE_BIT] <= wake_q;
            `RRF_OFF_RX_DATA,
            `RRF_OFF_RX_LAST:  rdata_out[7:0] <= rx_data_q;
            `RRF_OFF_INT_STAT: rdata_out[9:0] <= stat_q;
            `RRF_OFF_VECT:     rdata_out[7:0] <= vect;
            `RRF_OFF_BAUD:     rdata_out[15:0] <= baud_q;
            default:           rdata_out <= 32'h0000_0000;
         endcase
      end
   end

   // ===========================================================
   // assertions
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   AST_GAP_HOLD:
   assert property (gap_start |=> (tx_idle_hold_out && !tx_data_valid_out) [*2])
      else $error("idle gap not held after wake dummy write");
   AST_WAKE_LOAD:
   assert property (tx_load_in |=> !wake_q)
      else $error("wake select survived shifter load");
   AST_WAKE_SOFT:
   assert property (wake_q && !ctrl_q.soft_rel && !tx_load_in && !wr_in |=> wake_q)
      else $error("soft reset cleared wake select");
   AST_COMPAT_SET:
   assert property (!mod_held && !ctrl_q.lin && rx_event_in.valid && !wr_ctrl |=> rx_rdy_q)
      else $error("compat byte did not set flag");
   AST_MB_ERR:
   assert property (!rx_rdy_q && mode == rrf_pkg::RRF_MODE_LIN_MB && rx_event_in.valid &&
                    !rx_event_in.last |=> !rx_rdy_q)
      else $error("multibuffer flag set before frame end");
   AST_ONE_ERR:
   assert property (!rx_rdy_q && mode == rrf_pkg::RRF_MODE_LIN_ONE && rx_event_in.valid &&
                    rx_event_in.last && rx_event_in.err |=> !rx_rdy_q)
      else $error("errored last byte set flag");
   AST_IRQ:
   assert property (rx_set && !mod_held && int_en_q && !wr_in |-> ##2 irq_out)
      else $error("receive interrupt missing");
   AST_READ_CLR:
   assert property (rd_rx && !ctrl_q.lin && !rx_set |=> !rx_rdy_q)
      else $error("compat read did not clear flag");
   AST_HELD_CLR:
   assert property (mod_held |=> !rx_rdy_q)
      else $error("module reset left flag set");
   AST_VECT_KEEP:
   assert property (rx_rdy_q && rd_vect && !mod_held && !wr_ctrl |=> rx_rdy_q)
      else $error("vector read cleared flag");
   AST_W1C:
   assert property (rx_rdy_q && wr_flags && !wdata_in[`RRF_RX_RDY_BIT] && !mod_held
                    |=> rx_rdy_q)
      else $error("writing zero changed flag");
   AST_SET_WINS:
   assert property (rx_set && rx_clr && !mod_held && !wr_ctrl |=> rx_rdy_q)
      else $error("clear beat a same-cycle set");

endmodule : rrf_top

// [hdl/rrf_regs.svh]
/*
 * Register offsets, bit positions, reset values and counts of the
 * receive-ready flag and idle-line wake block.
 * Assumes it is included by bare name from hdl/ and sim/ sources.
 */
`ifndef RRF_REGS_SVH
`define RRF_REGS_SVH

// ===========================================================
// register offsets (byte addresses, one 32-bit word each)
`define RRF_ADDR_W          8
`define RRF_OFF_CTRL        8'h00
`define RRF_OFF_INT_SET     8'h04
`define RRF_OFF_INT_CLR     8'h08
`define RRF_OFF_FLAGS       8'h0c
`define RRF_OFF_TX_WAKE     8'h10
`define RRF_OFF_TX_DATA     8'h14
`define RRF_OFF_RX_DATA     8'h18
`define RRF_OFF_RX_LAST     8'h1c
`define RRF_OFF_INT_STAT    8'h20
`define RRF_OFF_VECT        8'h24
`define RRF_OFF_BAUD        8'h28

// ===========================================================
// field positions
`define RRF_CTRL_MOD_RST    0
`define RRF_CTRL_SOFT_REL   1
`define RRF_CTRL_LIN        2
`define RRF_CTRL_MBUF       3
`define RRF_CTRL_IDLE_LINE  4
`define RRF_RX_RDY_BIT      9
`define RRF_GAP_DONE_BIT    0
`define RRF_WAKE_BIT        0

// ===========================================================
// reset values, codes and counts
`define RRF_CTRL_RST        5'h00
`define RRF_BAUD_RST        16'h01b1
`define RRF_VECT_NONE       8'h00
`define RRF_VECT_RX         8'h0b
`define RRF_VECT_GAP        8'h01
`define RRF_IDLE_BITS       4'hb

`endif

// [hdl/rrf_pkg.sv]
/*
 * Types shared by the receive-ready flag block.
 * Assumes rrf_regs.svh supplies all numeric constants.
 */
package rrf_pkg;

   // ===========================================================
   // one received byte as handed over by the frame decoder
   typedef struct packed {
      logic       valid;
      logic       last;
      logic       err;
      logic [7:0] data;
   } rrf_rx_event_type;

   // ===========================================================
   // control bits written by software
   typedef struct packed {
      logic idle_line;
      logic mbuf;
      logic lin;
      logic soft_rel;
      logic mod_rst;
   } rrf_ctrl_type;

   // ===========================================================
   // which rule sets the receive-ready flag
   typedef enum logic [1:0] {
      RRF_MODE_COMPAT  = 2'b00,
      RRF_MODE_LIN_ONE = 2'b01,
      RRF_MODE_LIN_MB  = 2'b10
   } rrf_mode_type;

endpackage : rrf_pkg

// [hdl/rrf_idle_gap.sv]
/*
 * Idle gap timer: holds its busy output for a fixed number of bit ticks.
 * Assumes tick_in is a one-cycle enable at the bit rate on clk_in.
 */
`timescale 1ns/1ps
`include "rrf_regs.svh"

module rrf_idle_gap (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic start_in,
   input  wire logic tick_in,
   output logic      busy_out
);

   logic [3:0] left_q;

   // ===========================================================
   // count bit ticks down; a restart while busy starts over
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         left_q   <= 4'h0;
         busy_out <= 1'b0;
      end else if (start_in) begin
         left_q   <= `RRF_IDLE_BITS;
         busy_out <= 1'b1;
      end else if (busy_out && tick_in) begin
         left_q   <= left_q - 4'h1;
         busy_out <= (left_q != 4'h1);
      end
   end

endmodule : rrf_idle_gap

// [sim/rrf_node_model.sv]
/*
 * Behavioural model of the remote node beside the block: it hands received
 * bytes over as decoder events and takes transmit bytes into its shifter.
 * Assumes the bench pulses fire_in for one clk_in cycle per byte.
 */
`timescale 1ns/1ps

module rrf_node_model (
   input  wire logic                      clk_in,
   input  wire logic                      rst_n_in,
   input  wire logic                      fire_in,
   input  wire logic                      last_in,
   input  wire logic                      err_in,
   input  wire logic [7:0]                data_in,
   output rrf_pkg::rrf_rx_event_type      rx_event_out,
   input  wire logic                      tx_valid_in,
   input  wire logic                      tx_addr_in,
   input  wire logic [7:0]                tx_data_in,
   output logic                           tx_load_out,
   output logic                           got_addr_out,
   output logic      [7:0]                got_data_out
);
   // ===========================================================
   // receive side
   logic [1:0] wait_q;

   // outside a pulse the byte lines carry the inverse, so nothing stale passes
   assign rx_event_out = {fire_in, last_in & fire_in, err_in & fire_in,
                          fire_in ? data_in : ~data_in};

   // ===========================================================
   // transmit side: a slow shifter, it waits three cycles after each load
   always_ff @(posedge clk_in) begin
      tx_load_out <= 1'b0;
      if (!rst_n_in) begin
         wait_q       <= 2'h0;
         got_addr_out <= 1'b0;
         got_data_out <= 8'h00;
      end else if (wait_q != 2'h0) begin
         wait_q <= wait_q - 2'h1;
      end else if (tx_valid_in) begin
         tx_load_out  <= 1'b1;
         wait_q       <= 2'h3;
         got_addr_out <= tx_addr_in;
         got_data_out <= tx_data_in;
      end
   end

endmodule : rrf_node_model

// [sim/rrf_top_tb_top.sv]
/*
 * Self-checking bench of the receive-ready flag and idle wake block.
 * Assumes rrf_regs.svh is on the include path and the node model beside it.
 */
`timescale 1ns/1ps
`include "rrf_regs.svh"

module rrf_top_tb_top;
   logic                      clk_in, rst_n_in, wr_in, rd_in;
   logic [7:0]                addr_in, rxd, tx_data, got_data;
   logic [31:0]               wdata_in, rdata_out, rv;
   rrf_pkg::rrf_rx_event_type rx_event;
   logic                      fire, last, err, tx_load, tx_valid, tx_addr;
   logic                      hold, tick, irq, got_addr;
   int                        num_errors, comparisons, cycles, gap_ticks;

   // ===========================================================
   // instances
   rrf_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .rx_event_in(rx_event), .tx_load_in(tx_load), .tx_data_out(tx_data),
      .tx_data_valid_out(tx_valid), .tx_addr_frame_out(tx_addr),
      .tx_idle_hold_out(hold), .bit_tick_out(tick), .irq_out(irq));
   rrf_node_model node (.clk_in(clk_in), .rst_n_in(rst_n_in), .fire_in(fire),
      .last_in(last), .err_in(err), .data_in(rxd), .rx_event_out(rx_event),
      .tx_valid_in(tx_valid), .tx_addr_in(tx_addr), .tx_data_in(tx_data),
      .tx_load_out(tx_load), .got_addr_out(got_addr), .got_data_out(got_data));

   // ===========================================================
   // helpers
   task results;
      $display("checks %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results

   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      wr_in <= 1'b1; addr_in <= a; wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr

   // read data is taken in the cycle after the strobe; it holds until the next read
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_in);
      rd_in <= 1'b1; addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask : rd

   task rc(input logic [7:0] a, input int b, input logic exp);
      logic [31:0] d;
      rd(a, d);
      chk($sformatf("reg %h bit %0d", a, b), {31'h0, d[b]}, {31'h0, exp});
   endtask : rc

   task rxb(input logic [7:0] d, input logic l, input logic e);
      @(posedge clk_in);
      fire <= 1'b1; rxd <= d; last <= l; err <= e;
      @(posedge clk_in);
      fire <= 1'b0;
   endtask : rxb

   // waits until the node takes a byte into its shifter, bounded so a stall cannot hang
   task wait_load;
      int k;
      for (k = 0; k < 50 && !tx_load; k++) begin
         @(posedge clk_in);
         #1;
      end
   endtask : wait_load

   task sys_reset;
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (8) @(posedge clk_in);
      rst_n_in <= 1'b1;
   endtask : sys_reset

   // ===========================================================
   // scenarios
   task t_compat;
      wr(`RRF_OFF_CTRL, 32'h2);
      wr(`RRF_OFF_INT_SET, 32'h200);
      rxb(8'ha5, 1'b0, 1'b0);
      rc(`RRF_OFF_FLAGS, 9, 1'b1);
      chk("irq", {31'h0, irq}, 32'h1);
      rd(`RRF_OFF_VECT, rv);
      chk("vect", rv, {24'h0, `RRF_VECT_RX});
      rc(`RRF_OFF_FLAGS, 9, 1'b1);
      rd(`RRF_OFF_RX_DATA, rv);
      chk("rx byte", rv, 32'ha5);
      rc(`RRF_OFF_FLAGS, 9, 1'b0);
      wr(`RRF_OFF_INT_STAT, 32'h200);
      wr(`RRF_OFF_INT_CLR, 32'h200);
      rxb(8'h3c, 1'b0, 1'b0);
      repeat (3) @(posedge clk_in);
      #1 chk("irq masked", {31'h0, irq}, 32'h0);
      rc(`RRF_OFF_INT_STAT, 9, 1'b1);
      wr(`RRF_OFF_INT_STAT, 32'h200);
      rd(8'h3c, rv);
      chk("unmapped", rv, 32'h0);
   endtask : t_compat

   // writing zero leaves the flag, writing one clears it, a set beats a clear
   task t_w1c_race;
      wr(`RRF_OFF_FLAGS, 32'h0);
      rc(`RRF_OFF_FLAGS, 9, 1'b1);
      wr(`RRF_OFF_FLAGS, 32'h200);
      rc(`RRF_OFF_FLAGS, 9, 1'b0);
      @(posedge clk_in);
      fire <= 1'b1; rxd <= 8'h77; last <= 1'b0; err <= 1'b0;
      wr_in <= 1'b1; addr_in <= `RRF_OFF_FLAGS; wdata_in <= 32'h200;
      @(posedge clk_in);
      fire <= 1'b0; wr_in <= 1'b0;
      rc(`RRF_OFF_FLAGS, 9, 1'b1);
      wr(`RRF_OFF_FLAGS, 32'h200);
   endtask : t_w1c_race

   task t_lin_mb;
      wr(`RRF_OFF_CTRL, 32'h0e);
      rxb(8'h01, 1'b0, 1'b0);
      rc(`RRF_OFF_FLAGS, 9, 1'b0);
      rxb(8'h02, 1'b1, 1'b0);
      rc(`RRF_OFF_FLAGS, 9, 1'b1);
      rd(`RRF_OFF_RX_LAST, rv);
      rc(`RRF_OFF_FLAGS, 9, 1'b0);
      rxb(8'h03, 1'b0, 1'b1);
      rxb(8'h04, 1'b1, 1'b0);
      rc(`RRF_OFF_FLAGS, 9, 1'b0);
      rxb(8'h06, 1'b0, 1'b0);
      rxb(8'h07, 1'b1, 1'b0);
      rc(`RRF_OFF_FLAGS, 9, 1'b1);
      wr(`RRF_OFF_FLAGS, 32'h200);
   endtask : t_lin_mb

   task t_lin_one;
      wr(`RRF_OFF_CTRL, 32'h06);
      rxb(8'h11, 1'b0, 1'b0);
      rc(`RRF_OFF_FLAGS, 9, 1'b1);
      wr(`RRF_OFF_FLAGS, 32'h200);
      rxb(8'h12, 1'b1, 1'b1);
      rc(`RRF_OFF_FLAGS, 9, 1'b0);
      rxb(8'h13, 1'b1, 1'b0);
      rc(`RRF_OFF_FLAGS, 9, 1'b1);
      rd(`RRF_OFF_RX_LAST, rv);
      rc(`RRF_OFF_FLAGS, 9, 1'b0);
   endtask : t_lin_one

   task t_resets;
      wr(`RRF_OFF_CTRL, 32'h2);
      rxb(8'h21, 1'b0, 1'b0);
      wr(`RRF_OFF_CTRL, 32'h3);
      rc(`RRF_OFF_FLAGS, 9, 1'b0);
      wr(`RRF_OFF_CTRL, 32'h2);
      rxb(8'h22, 1'b0, 1'b0);
      wr(`RRF_OFF_CTRL, 32'h0);
      rxb(8'h23, 1'b0, 1'b0);
      rc(`RRF_OFF_FLAGS, 9, 1'b0);
      wr(`RRF_OFF_CTRL, 32'h2);
      rxb(8'h24, 1'b0, 1'b0);
      sys_reset();
      wr(`RRF_OFF_CTRL, 32'h2);
      rc(`RRF_OFF_FLAGS, 9, 1'b0);
   endtask : t_resets

   // the gap is measured in bit ticks, a short baud keeps the run brief;
   // the next frame is written inside the gap so it must be held back
   task t_wake;
      int k;
      wr(`RRF_OFF_BAUD, 32'h2);
      wr(`RRF_OFF_CTRL, 32'h12);
      wr(`RRF_OFF_TX_WAKE, 32'h1);
      wr(`RRF_OFF_TX_DATA, 32'h0);
      #1 chk("idle hold", {31'h0, hold}, 32'h1);
      wr(`RRF_OFF_TX_DATA, 32'h5a);
      #1;
      for (k = 0; k < 400 && hold; k++) begin
         chk("no send in gap", {31'h0, tx_valid}, 32'h0);
         @(posedge clk_in);
         #1;
      end
      chk("gap ticks", gap_ticks, {28'h0, `RRF_IDLE_BITS});
      wait_load();
      chk("tx byte", {24'h0, got_data}, 32'h5a);
      chk("addr frame", {31'h0, got_addr}, 32'h1);
      rc(`RRF_OFF_TX_WAKE, 0, 1'b0);
      wr(`RRF_OFF_TX_WAKE, 32'h1);
      wr(`RRF_OFF_CTRL, 32'h10);
      rc(`RRF_OFF_TX_WAKE, 0, 1'b1);
      sys_reset();
      rc(`RRF_OFF_TX_WAKE, 0, 1'b0);
      // address-bit mode: the wake bit marks the frame and the shifter load clears it
      wr(`RRF_OFF_CTRL, 32'h2);
      wr(`RRF_OFF_TX_WAKE, 32'h1);
      wr(`RRF_OFF_TX_DATA, 32'h66);
      wait_load();
      chk("addr bit frame", {31'h0, got_addr}, 32'h1);
      chk("addr bit byte", {24'h0, got_data}, 32'h66);
      rc(`RRF_OFF_TX_WAKE, 0, 1'b0);
   endtask : t_wake

   // ===========================================================
   // clock, watchdog and main sequence
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   // the whole run needs a few hundred cycles; this cuts a hang short,
   // and counts the bit ticks that the gap timer consumes while it holds
   always @(posedge clk_in) begin
      cycles++;
      if (hold && tick) begin
         gap_ticks++;
      end
      if (cycles == 20000) begin
         num_errors++;
         results();
      end
   end

   initial begin
      rst_n_in = 1'b0; wr_in = 1'b0; rd_in = 1'b0; addr_in = 8'h00;
      wdata_in = 32'h0; fire = 1'b0; last = 1'b0; err = 1'b0; rxd = 8'h00;
      num_errors = 0; comparisons = 0; cycles = 0; gap_ticks = 0;
      repeat (8) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_compat();
      t_w1c_race();
      t_lin_mb();
      t_lin_one();
      t_resets();
      t_wake();
      results();
   end

endmodule : rrf_top_tb_top
